// ==== src/rx_highpass_dc_offset_cal.sv ====
// high-pass stage and dc offset calibration sequencer with ahb-lite regs
`timescale 1ns/1ns
// Overview of operation
// - select bit one inserts high-pass after channel filter on I and Q.
// - high-pass is first-order IIR, coefficient from 4-bit cutoff code.
// - each cutoff step doubles cutoff; top two bits set saturate.
// - stage runs at channel filter output rate, cutoff follows group.
// - analog start runs mixer calibration 40 us then self-clears.
// - results cleared by hardware or software reset.
// - digital start averages both taps, subtracts, then self-clears.
// - channel-filter-only start calibrates that tap, then self-clears.
// - agc-only start calibrates agc tap, then self-clears.
// - result registers show channel result on 00, agc result on 11.
// - separate result per pga gain; readback follows current gain.
// - any channel calibration takes channel time; agc-only takes agc time.
// - channel time depends on filter group and averaging field.
// - agc time follows averaging field, roughly doubling per step.
// - analog and digital calibrations start independently.
// - agc offset sampled from branch before the channel filter.
// - offset canceller active only while its enable bit is one.
module rx_highpass_dc_offset_cal
  import rx_hp_cal_pkg::*;
#(
  parameter int W = 24,
  parameter int CYC_SCALE = CYC_PER_100US
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_soft_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // receive datapath
  input wire logic i_chf_valid,
  input wire logic signed [W-1:0] i_chf_i,
  input wire logic signed [W-1:0] i_chf_q,
  input wire logic i_pre_valid,
  input wire logic signed [W-1:0] i_pre_i,
  input wire logic signed [W-1:0] i_pre_q,
  output logic o_valid,
  output logic signed [W-1:0] o_i,
  output logic signed [W-1:0] o_q,
  output logic signed [W-1:0] o_agc_i,
  output logic signed [W-1:0] o_agc_q,
  // analog and canceller controls
  output logic o_mixer_cal_run,
  output logic o_realtime_offset_cancel_en_active
);
  import rx_hp_cal_pkg::*;
  typedef enum {IDLE, RUN} cal_state_t;

  function automatic int chf_time(input logic [3:0] fsel,
    input logic [1:0] av);
    int idx;
    idx = int'(av) + ((fsel >= FSEL_LAST) ? 2 : (fsel >= FSEL_MID) ? 1 : 0);
    case (idx)
      0: chf_time = CHF_T_0;
      1: chf_time = CHF_T_1;
      2: chf_time = CHF_T_2;
      3: chf_time = CHF_T_3;
      4: chf_time = CHF_T_4;
      default: chf_time = CHF_T_5;
    endcase
  endfunction

  function automatic int agc_time(input logic [1:0] av);
    case (av)
      2'd0: agc_time = AGC_T_0;
      2'd1: agc_time = AGC_T_1;
      2'd2: agc_time = AGC_T_2;
      default: agc_time = AGC_T_3;
    endcase
  endfunction

  logic [31:0] ctrl_reg;
  logic [3:0] cal_reg;
  logic [31:0] ana_cnt_reg;
  logic [31:0] dig_cnt_reg;
  logic dig_chf_reg;
  logic dig_agc_reg;
  cal_state_t dig_state_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] rdata_next;
  logic clr;
  logic [3:0] wcal;
  logic [5:0] pga;
  logic [1:0] rsel;
  logic hp_sel;
  logic [3:0] fsel;
  logic [3:0] cut;
  logic [4:0] shift;
  logic signed [W-1:0] chf_avg_i;
  logic signed [W-1:0] chf_avg_q;
  logic signed [W-1:0] agc_avg_i;
  logic signed [W-1:0] agc_avg_q;
  logic signed [W-1:0] hp_i;
  logic signed [W-1:0] hp_q;
  logic signed [W-1:0] chf_res_i [PGA_STEPS];
  logic signed [W-1:0] chf_res_q [PGA_STEPS];
  logic signed [W-1:0] agc_res_i [PGA_STEPS];
  logic signed [W-1:0] agc_res_q [PGA_STEPS];
  logic dig_done;

  assign clr = i_soft_rst;
  assign hp_sel = ctrl_reg[HPSEL_BIT];
  assign cut = ctrl_reg[CUT_LSB+3:CUT_LSB];
  assign fsel = ctrl_reg[FSEL_LSB+3:FSEL_LSB];
  assign rsel = ctrl_reg[RSEL_LSB+1:RSEL_LSB];
  assign pga = ctrl_reg[PGA_LSB+5:PGA_LSB];

  // bus: zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else if (i_hready)
    begin
      wr_pend_reg <= i_hsel && i_htrans[1] && i_hwrite;
      rd_pend_reg <= i_hsel && i_htrans[1] && !i_hwrite;
      addr_reg <= i_haddr;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      ctrl_reg <= CTRL_RST;
    else if (wr_pend_reg && addr_reg == CTRL_OFS)
      ctrl_reg <= i_hwdata;
  end

  assign wcal = (wr_pend_reg && addr_reg == CAL_OFS) ? i_hwdata[3:0] : 4'h0;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst || clr)
      ana_cnt_reg <= 32'h0;
    else if (wcal[ANA_BIT] && !cal_reg[ANA_BIT])
      ana_cnt_reg <= 32'(ANA_CAL_CYC - 1);
    else if (ana_cnt_reg != 32'h0)
      ana_cnt_reg <= ana_cnt_reg - 32'h1;
  end

  assign dig_done = dig_state_reg == RUN && dig_cnt_reg == 32'h0;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst || clr)
    begin
      dig_state_reg <= IDLE;
      dig_cnt_reg <= 32'h0;
      dig_chf_reg <= 1'b0;
      dig_agc_reg <= 1'b0;
    end
    else
    begin
      case (dig_state_reg)
        IDLE:
        begin
          if (|wcal[AGC_BIT:DIG_BIT])
          begin
            dig_state_reg <= RUN;
            dig_chf_reg <= wcal[DIG_BIT] | wcal[CHF_BIT];
            dig_agc_reg <= wcal[DIG_BIT] | wcal[AGC_BIT];
            // channel time wins when channel filter involved
            // channel time by group and average
            if (wcal[DIG_BIT] | wcal[CHF_BIT])
              dig_cnt_reg <= 32'(chf_time(fsel,
                ctrl_reg[CHAVE_LSB+1:CHAVE_LSB]) * CYC_SCALE - 1);
            else
              dig_cnt_reg <= 32'(agc_time(
                ctrl_reg[AGCAVE_LSB+1:AGCAVE_LSB]) * CYC_SCALE / 100 - 1);
          end
        end
        RUN:
        begin
          if (dig_cnt_reg == 32'h0)
            dig_state_reg <= IDLE;
          else
            dig_cnt_reg <= dig_cnt_reg - 32'h1;
        end
        default: dig_state_reg <= IDLE;
      endcase
    end
  end

  // start bits read one while running
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst || clr)
      cal_reg <= 4'h0;
    else
    begin
      cal_reg[ANA_BIT] <= (wcal[ANA_BIT] && !cal_reg[ANA_BIT])
        || ana_cnt_reg > 32'h1;
      if (dig_done)
        cal_reg[AGC_BIT:DIG_BIT] <= 3'b000;
      else if (dig_state_reg == IDLE)
        cal_reg[AGC_BIT:DIG_BIT] <= wcal[AGC_BIT:DIG_BIT];
    end
  end
  assign o_mixer_cal_run = cal_reg[ANA_BIT];

  offset_avg #(.W(W)) u_chf_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_run(dig_chf_reg && dig_state_reg == RUN), .i_step(i_chf_valid),
    .i_x(i_chf_i), .o_avg(chf_avg_i));
  offset_avg #(.W(W)) u_chf_q (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_run(dig_chf_reg && dig_state_reg == RUN), .i_step(i_chf_valid),
    .i_x(i_chf_q), .o_avg(chf_avg_q));
  // agc tap is the pre-filter branch
  offset_avg #(.W(W)) u_agc_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_run(dig_agc_reg && dig_state_reg == RUN), .i_step(i_pre_valid),
    .i_x(i_pre_i), .o_avg(agc_avg_i));
  offset_avg #(.W(W)) u_agc_q (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_run(dig_agc_reg && dig_state_reg == RUN), .i_step(i_pre_valid),
    .i_x(i_pre_q), .o_avg(agc_avg_q));

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst || clr)
    begin
      for (int k = 0; k < PGA_STEPS; k++)
      begin
        chf_res_i[k] <= '0;
        chf_res_q[k] <= '0;
        agc_res_i[k] <= '0;
        agc_res_q[k] <= '0;
      end
    end
    else if (dig_done)
    begin
      if (dig_chf_reg)
      begin
        chf_res_i[pga] <= chf_avg_i;
        chf_res_q[pga] <= chf_avg_q;
      end
      if (dig_agc_reg)
      begin
        agc_res_i[pga] <= agc_avg_i;
        agc_res_q[pga] <= agc_avg_q;
      end
    end
  end

  // cutoff doubles per code, top codes saturate
  // one sample step per channel filter output, group shifts cutoff
  always_comb
  begin
    shift = (cut[3:2] == 2'b11) ? 5'd4 : 5'(16 - int'(cut));
    if (fsel >= FSEL_LAST)
      shift = shift + 5'd2;
    else if (fsel >= FSEL_MID)
      shift = shift + 5'd1;
  end

  hp_iir_stage #(.W(W)) u_hp_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_en(hp_sel), .i_shift(shift), .i_step(i_chf_valid),
    .i_x(W'(i_chf_i - chf_res_i[pga])), .o_y(hp_i));
  hp_iir_stage #(.W(W)) u_hp_q (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_en(hp_sel), .i_shift(shift), .i_step(i_chf_valid),
    .i_x(W'(i_chf_q - chf_res_q[pga])), .o_y(hp_q));

  assign o_i = hp_i;
  assign o_q = hp_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      o_valid <= 1'b0;
    else
      o_valid <= i_chf_valid;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      o_agc_i <= '0;
      o_agc_q <= '0;
    end
    else if (i_pre_valid)
    begin
      o_agc_i <= W'(i_pre_i - agc_res_i[pga]);
      o_agc_q <= W'(i_pre_q - agc_res_q[pga]);
    end
  end

  // canceller gated by enable; left to software
  assign o_realtime_offset_cancel_en_active = ctrl_reg[REALTIME_OFFSET_CANCEL_EN_BIT];

  always_comb
  begin
    rdata_next = 32'h0;
    case (addr_reg)
      CTRL_OFS: rdata_next = ctrl_reg;
      CAL_OFS: rdata_next = {28'h0, cal_reg};
      RES_I_OFS: rdata_next = (rsel == RSEL_AGC) ?
        32'(unsigned'(agc_res_i[pga])) : (rsel == RSEL_CHF) ?
        32'(unsigned'(chf_res_i[pga])) : 32'h0;
      RES_Q_OFS: rdata_next = (rsel == RSEL_AGC) ?
        32'(unsigned'(agc_res_q[pga])) : (rsel == RSEL_CHF) ?
        32'(unsigned'(chf_res_q[pga])) : 32'h0;
      STAT_OFS: rdata_next = {30'h0, dig_state_reg == RUN,
        o_mixer_cal_run};
      default: rdata_next = 32'h0;
    endcase
  end
  assign o_hrdata = rd_pend_reg ? rdata_next : 32'h0;
endmodule

// ==== src/rx_hp_cal_pkg.sv ====
// shared constants for the receive high-pass and offset calibration block
package rx_hp_cal_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CAL_OFS = 8'h04;
  localparam logic [7:0] RES_I_OFS = 8'h08;
  localparam logic [7:0] RES_Q_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  // control register fields
  localparam int HPSEL_BIT = 0;
  localparam int REALTIME_OFFSET_CANCEL_EN_BIT = 1;
  localparam int CUT_LSB = 4;
  localparam int FSEL_LSB = 8;
  localparam int CHAVE_LSB = 12;
  localparam int AGCAVE_LSB = 14;
  localparam int RSEL_LSB = 16;
  localparam int PGA_LSB = 20;
  // calibration register fields
  localparam int ANA_BIT = 0;
  localparam int DIG_BIT = 1;
  localparam int CHF_BIT = 2;
  localparam int AGC_BIT = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // readback select codes
  localparam logic [1:0] RSEL_CHF = 2'b00;
  localparam logic [1:0] RSEL_AGC = 2'b11;
  // timing at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int ANA_CAL_US = 40;
  localparam int ANA_CAL_CYC = ANA_CAL_US * CLK_MHZ;
  // channel filter cal times in 0.1 ms, indexed by group+average
  localparam int CHF_T_0 = 19;
  localparam int CHF_T_1 = 24;
  localparam int CHF_T_2 = 33;
  localparam int CHF_T_3 = 51;
  localparam int CHF_T_4 = 86;
  localparam int CHF_T_5 = 157;
  // agc cal times in us
  localparam int AGC_T_0 = 131;
  localparam int AGC_T_1 = 242;
  localparam int AGC_T_2 = 464;
  localparam int AGC_T_3 = 909;
  localparam int CYC_PER_100US = 100 * CLK_MHZ;
  // channel filter group boundaries
  localparam logic [3:0] FSEL_MID = 4'h4;
  localparam logic [3:0] FSEL_LAST = 4'h9;
  localparam int PGA_STEPS = 64;
endpackage

// ==== src/hp_iir_stage.sv ====
// first-order high-pass stage on one receive channel
`timescale 1ns/1ns
module hp_iir_stage
  import rx_hp_cal_pkg::*;
#(
  parameter int W = 24
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_en,
  input wire logic [4:0] i_shift,
  input wire logic i_step,
  // data
  input wire logic signed [W-1:0] i_x,
  output logic signed [W-1:0] o_y
);
  import rx_hp_cal_pkg::*;
  // dc estimate kept with 16 guard bits so slow cutoffs still track
  logic signed [W+15:0] acc_reg;
  logic signed [W+15:0] acc_next;
  logic signed [W-1:0] est;
  assign est = acc_reg[W+15:16];
  always_comb
  begin
    // signed cast so negative errors shift in sign bits, not zeros
    acc_next = acc_reg + (signed'({i_x - est, 16'h0000}) >>> i_shift);
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      acc_reg <= '0;
    else if (!i_en)
      acc_reg <= '0;
    else if (i_step)
      acc_reg <= acc_next;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      o_y <= '0;
    else if (i_step)
      o_y <= i_en ? W'(i_x - est) : i_x;
  end
endmodule

// ==== src/offset_avg.sv ====
// running dc average of one channel during calibration
`timescale 1ns/1ns
module offset_avg
#(
  parameter int W = 24
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_run,
  input wire logic i_step,
  // data
  input wire logic signed [W-1:0] i_x,
  output logic signed [W-1:0] o_avg
);
  // exponential average, weight 1/256, cheaper than a true window
  logic signed [W+7:0] acc_reg;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      acc_reg <= '0;
    else if (i_run && i_step)
      acc_reg <= acc_reg + (W+8)'(i_x) - (W+8)'(acc_reg >>> 8);
  end
  assign o_avg = acc_reg[W+7:8];
endmodule

// ==== tb/rx_hp_cal_asserts.sv ====
// checker for the high-pass and offset calibration block ports
`timescale 1ns/1ns
module rx_hp_cal_asserts
  import rx_hp_cal_pkg::*;
#(
  parameter int W = 24
)
(
  input wire logic i_ref_clk, i_nrst, i_soft_rst,
  input wire logic i_hsel, i_hwrite, i_hready,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic [31:0] i_hwdata, o_hrdata,
  input wire logic o_hreadyout, o_hresp,
  input wire logic i_chf_valid, i_pre_valid, o_valid,
  input wire logic signed [W-1:0] o_agc_i,
  input wire logic o_mixer_cal_run, o_realtime_offset_cancel_en_active
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic wr_q;
  logic rd_q;
  logic [12:0] run_cnt;
  // address phases seen, and length of each mixer run
  always_ff @(posedge i_ref_clk)
  begin
    wr_q <= i_hsel && i_htrans[1] && i_hready && i_hwrite
      && i_haddr == CTRL_OFS;
    rd_q <= i_hsel && i_htrans[1] && i_hready && !i_hwrite;
    run_cnt <= o_mixer_cal_run ? run_cnt + 13'h1 : 13'h0;
  end
  out_rate_a: assert property (i_chf_valid |=> o_valid)
    else $error("output sample missing");
  valid_cause_a: assert property (o_valid |-> $past(i_chf_valid))
    else $error("output sample without input");
  mix_len_a: assert property ($fell(o_mixer_cal_run)
    && !$past(i_soft_rst) |-> run_cnt >= ANA_CAL_CYC - 2
    && run_cnt <= ANA_CAL_CYC + 2) else $error("mixer run length");
  rst_clear_a: assert property ($rose(i_nrst) |->
    !o_mixer_cal_run && !o_valid && o_agc_i == '0)
    else $error("state not cleared by reset");
  realtime_offset_cancel_en_en_a: assert property (wr_q |=>
    o_realtime_offset_cancel_en_active == $past(i_hwdata[REALTIME_OFFSET_CANCEL_EN_BIT]))
    else $error("canceller enable mismatch");
  rd_idle_a: assert property (!rd_q |-> o_hrdata == 32'h0)
    else $error("read data outside data phase");
  bus_ok_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or error");
  agc_upd_a: assert property ($changed(o_agc_i) |->
    $past(i_pre_valid) || $past(i_soft_rst))
    else $error("agc output moved without sample");
endmodule
bind rx_highpass_dc_offset_cal rx_hp_cal_asserts #(.W(W)) chk (.*);

// ==== tb/rx_stream_model.sv ====
// receive sample source for the channel filter and agc taps
`timescale 1ns/1ns
module rx_stream_model
#(
  parameter int DC = 4096,
  parameter int PRE = 2048
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_valid,
  output logic signed [23:0] o_ci, o_cq, o_pi, o_pq
);
  logic tgl;
  // agc tap carries its own offset, apart from the filter
  // toggle keeps data moving so a stuck path shows
  always_ff @(posedge i_clk)
  begin
    tgl <= i_nrst ? ~tgl : 1'b0;
    o_valid <= i_nrst;
    o_ci <= 24'(DC + (tgl ? 16 : -16));
    o_cq <= 24'(-DC + (tgl ? 16 : -16));
    o_pi <= 24'(PRE + (tgl ? 8 : -8));
    o_pq <= 24'(-PRE);
  end
endmodule

// ==== tb/test_rx_highpass_dc_offset_cal.sv ====
// register-level bench for the high-pass and offset calibration block
`timescale 1ns/1ns
module test_rx_highpass_dc_offset_cal;
  import rx_hp_cal_pkg::*;
  localparam int CS = 100;
  localparam int DC = 4096;
  localparam int PRE = 2048;
  logic clk = 0, nrst = 0, srst = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, rd;
  logic signed [23:0] li;
  wire [31:0] hrdata;
  wire rdy, hresp, cv, ov, mix, realtime_offset_cancel_en;
  wire signed [23:0] ci, cq, pi, pq, oi, oq, ai, aq;
  int errors = 0, compares = 0, cyc = 0;
  rx_stream_model #(.DC(DC), .PRE(PRE)) src (.i_clk(clk),
    .i_nrst(nrst), .o_valid(cv), .o_ci(ci), .o_cq(cq), .o_pi(pi),
    .o_pq(pq));
  rx_highpass_dc_offset_cal #(.CYC_SCALE(CS)) uut (.i_ref_clk(clk),
    .i_nrst(nrst), .i_soft_rst(srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
    .o_hreadyout(rdy), .o_hresp(hresp), .i_chf_valid(cv), .i_chf_i(ci),
    .i_chf_q(cq), .i_pre_valid(cv), .i_pre_i(pi), .i_pre_q(pq),
    .o_valid(ov), .o_i(oi), .o_q(oq), .o_agc_i(ai), .o_agc_q(aq),
    .o_mixer_cal_run(mix), .o_realtime_offset_cancel_en_active(realtime_offset_cancel_en));
  initial forever #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) li <= ci;
  task stop_test;
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  function automatic logic near(logic [23:0] v, int e);
    int s;
    s = int'(signed'(v));
    return s > e - 64 && s < e + 64;
  endfunction
  task edge_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      errors++;
      stop_test;
    end
  endtask
  task xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    edge_rdy;
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy;
    rd = hrdata;
  endtask
  // one start bit per write, polled until it drops
  task cal(int b, int exp);
    int t0;
    xfer(1, CAL_OFS, 32'h1 << b);
    t0 = cyc;
    xfer(0, CAL_OFS, 0);
    chk("cal_busy", rd[b], 1);
    while (rd[b] && cyc - t0 < 2 * exp + 100)
      xfer(0, CAL_OFS, 0);
    chk("cal_time", cyc - t0 >= exp - 8 && cyc - t0 <= exp + 8, 1);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    xfer(0, CTRL_OFS, 0);
    chk("ctrl_rst", rd, CTRL_RST);
    xfer(1, 8'h14, 32'hffff_ffff);
    xfer(0, 8'h14, 0);
    chk("unmapped", rd, 0);
    #1;
    chk("thru_i", oi, li);
    chk("out_valid", ov, 1);
    for (int v = 1; v >= 0; v--)
    begin
      xfer(1, CTRL_OFS, v << REALTIME_OFFSET_CANCEL_EN_BIT);
      @(posedge clk) #1;
      chk("realtime_offset_cancel_en", realtime_offset_cancel_en, v);
    end
    xfer(1, CTRL_OFS, 32'h1 | 32'hc << CUT_LSB);
    repeat (3000) @(posedge clk);
    #1;
    chk("hp_dc", near(oi, 0), 1);
    xfer(1, CTRL_OFS, 0);
    cal(ANA_BIT, ANA_CAL_CYC);
    cal(DIG_BIT, CHF_T_0 * CS);
    #1;
    chk("sub_i", near(oi, 0), 1);
    chk("sub_q", near(oq, 0), 1);
    chk("agc_sub_i", near(ai, 0), 1);
    chk("agc_sub_q", near(aq, 0), 1);
    xfer(0, RES_I_OFS, 0);
    chk("res_i", near(rd[23:0], DC), 1);
    xfer(0, RES_Q_OFS, 0);
    chk("res_q", near(rd[23:0], -DC), 1);
    xfer(1, CTRL_OFS, 32'(RSEL_AGC) << RSEL_LSB);
    xfer(0, RES_I_OFS, 0);
    chk("agc_i", near(rd[23:0], PRE), 1);
    xfer(1, CTRL_OFS, 32'h1 << RSEL_LSB);
    xfer(0, RES_I_OFS, 0);
    chk("sel01", rd, 0);
    xfer(1, CTRL_OFS, 32'h5 << PGA_LSB);
    xfer(0, RES_I_OFS, 0);
    chk("pga5", rd, 0);
    xfer(1, CTRL_OFS, 0);
    xfer(0, RES_I_OFS, 0);
    chk("pga0", near(rd[23:0], DC), 1);
    srst <= 1;
    @(posedge clk);
    srst <= 0;
    xfer(0, RES_I_OFS, 0);
    chk("soft_rst", rd, 0);
    xfer(1, CTRL_OFS, 32'h3900);
    cal(CHF_BIT, CHF_T_5 * CS);
    #1;
    chk("chf_only", near(ai, PRE), 1);
    xfer(1, CTRL_OFS, 32'h1400);
    cal(DIG_BIT, CHF_T_2 * CS);
    xfer(1, CTRL_OFS, 32'hc000);
    cal(AGC_BIT, AGC_T_3 * CS / 100);
    xfer(1, CTRL_OFS, 0);
    cal(AGC_BIT, AGC_T_0 * CS / 100);
    #1;
    chk("agc_only", near(ai, 0), 1);
    xfer(1, CAL_OFS, 32'h1 << ANA_BIT);
    cal(DIG_BIT, CHF_T_0 * CS);
    chk("both_run", mix, 1);
    xfer(0, STAT_OFS, 0);
    chk("status", rd, 32'h1);
    stop_test;
  end
endmodule
